// File: design/mpb_pkg.sv
/*
 * Package of the motion profile parameter bank: register indices, field
 * positions, preset values and the operating mode codes.
 * Assumes a single 25 MHz clock domain and an Avalon-MM slave with 32-bit data.
 */
package mpb_pkg;

   // ************************************************************
   // Register indices (object indices); byte address is four times the index.
   // ************************************************************
   localparam logic [15:0] IDX_JERK_BASE = 16'h60A4;
   localparam logic [15:0] IDX_POS_UNIT = 16'h60A8;
   localparam logic [15:0] IDX_VEL_UNIT = 16'h60A9;
   localparam logic [15:0] IDX_POS_OFS = 16'h60B0;
   localparam logic [15:0] IDX_VEL_OFS = 16'h60B1;
   localparam logic [15:0] IDX_TRQ_OFS = 16'h60B2;
   // Jerk array subindices live in a window of their own above the object.
   localparam logic [15:0] IDX_JERK_SUB_BASE = 16'h7000;
   localparam logic [15:0] IDX_MODE = 16'h7010;
   localparam logic [15:0] IDX_SETPOINT = 16'h7011;
   localparam logic [15:0] IDX_JERK_STAT = 16'h7012;

   // ************************************************************
   // Field positions.
   // ************************************************************
   localparam int EXP_LSB = 24;
   localparam int NUM_LSB = 16;
   localparam int DEN_LSB = 8;
   localparam int FIELD_W = 8;

   // ************************************************************
   // Preset values.
   // ************************************************************
   localparam logic [7:0] JERK_COUNT = 8'h04;
   localparam logic [31:0] JERK_RESET = 32'h000003E8;
   localparam logic [31:0] POS_UNIT_RESET = 32'hFF410000;
   localparam logic [31:0] VEL_UNIT_RESET = 32'h00B44700;
   localparam logic [31:0] POS_UNIT_MASK = 32'hFFFF0000;
   localparam logic [31:0] VEL_UNIT_MASK = 32'hFFFFFF00;
   localparam logic [31:0] OFS_RESET = 32'h00000000;
   localparam logic [15:0] TRQ_RESET = 16'h0000;

   // Operating modes; all but MODE_OTHER consume at least one offset, only MODE_CSP all three.
   localparam logic [2:0] MODE_OTHER = 3'h0;
   localparam logic [2:0] MODE_CSP = 3'h1;
   localparam logic [2:0] MODE_CSV = 3'h2;
   localparam logic [2:0] MODE_CST = 3'h3;
   localparam logic [2:0] MODE_CLKDIR = 3'h4;

   // Ramp segment selector codes.
   localparam logic [1:0] SEG_BEGIN_ACC = 2'h0;
   localparam logic [1:0] SEG_BEGIN_DEC = 2'h1;
   localparam logic [1:0] SEG_END_ACC = 2'h2;
   localparam logic [1:0] SEG_END_DEC = 2'h3;

   // Bus answer states, Gray coded.
   typedef enum logic [1:0] {
      MPB_IDLE = 2'b00,
      MPB_ANSWER = 2'b01
   } mpb_bus_state_type;

endpackage

// File: design/mpb_setpoint_adder.sv
/*
 * Offset adder: adds the setpoint offsets to the incoming set values,
 * gated by the operating mode, with registered outputs.
 * Assumes set values and mode come from logic on the same clock.
 */
module mpb_setpoint_adder (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [2:0] mode_in,
   input wire logic [31:0] pos_set_in,
   input wire logic [31:0] vel_set_in,
   input wire logic [15:0] trq_set_in,
   input wire logic [31:0] pos_ofs_in,
   input wire logic [31:0] vel_ofs_in,
   input wire logic [15:0] trq_ofs_in,
   output logic [31:0] pos_out,
   output logic [31:0] vel_out,
   output logic [15:0] trq_out
);

   // ************************************************************
   // Mode gates.
   // ************************************************************
   wire logic pos_en = (mode_in == mpb_pkg::MODE_CSP);
   wire logic vel_en = (mode_in == mpb_pkg::MODE_CSP) || (mode_in == mpb_pkg::MODE_CSV)
      || (mode_in == mpb_pkg::MODE_CLKDIR);
   wire logic trq_en = (mode_in == mpb_pkg::MODE_CSP) || (mode_in == mpb_pkg::MODE_CST)
      || (mode_in == mpb_pkg::MODE_CLKDIR);
   // Sums wrap in two's complement; saturation belongs to the ramp stage.
   wire logic [31:0] pos_sum = pos_set_in + (pos_en ? pos_ofs_in : 32'h00000000);
   wire logic [31:0] vel_sum = vel_set_in + (vel_en ? vel_ofs_in : 32'h00000000);
   // Torque offset is in tenths of a percent, same unit as the set value.
   wire logic [15:0] trq_sum = trq_set_in + (trq_en ? trq_ofs_in : 16'h0000);

   // Registers the sums one cycle after the inputs.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pos_out <= 32'h00000000;
         vel_out <= 32'h00000000;
         trq_out <= 16'h0000;
      end else begin
         pos_out <= pos_sum;
         vel_out <= vel_sum;
         trq_out <= trq_sum;
      end
   end

endmodule

// File: design/mpb_bank.sv
/*
 * Motion profile parameter bank: jerk limits, unit words and setpoint
 * offsets, reached over an Avalon-MM slave with waitrequest.
 * Assumes one 25 MHz clock, asynchronous active-low reset, and a master
 * that holds each request until it sees waitrequest low.
 */
module mpb_bank (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [17:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic [1:0] seg_sel_in,
   input wire logic [31:0] pos_set_in,
   input wire logic [31:0] vel_set_in,
   input wire logic [15:0] trq_set_in,
   output logic [31:0] jerk_out,
   output logic jerk_limited_out,
   output logic [7:0] pos_exp_out,
   output logic [7:0] pos_unit_out,
   output logic [7:0] vel_exp_out,
   output logic [7:0] vel_num_out,
   output logic [7:0] vel_den_out,
   output logic [31:0] pos_out,
   output logic [31:0] vel_out,
   output logic [15:0] trq_out
);

   // ************************************************************
   // Helpers.
   // ************************************************************

   // Merges write data into an old value under the byte enables.
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Picks one 8-bit field out of a unit word.
   function automatic logic [7:0] field8(input logic [31:0] w, input int lsb);
      return w[lsb +: mpb_pkg::FIELD_W];
   endfunction

   // ************************************************************
   // Storage.
   // ************************************************************
   logic [31:0] jerk_q [4]; // Jerk limits, indexed by subindex minus one.
   logic [31:0] pos_unit_q; // Position unit word.
   logic [31:0] vel_unit_q; // Velocity unit word.
   logic [31:0] pos_ofs_q; // Position offset, signed.
   logic [31:0] vel_ofs_q; // Velocity offset, signed.
   logic [15:0] trq_ofs_q; // Torque offset, signed tenths of a percent.
   logic [2:0] mode_q; // Operating mode written by software.
   mpb_pkg::mpb_bus_state_type state_q; // Bus answer state.
   logic [31:0] rdata_q; // Captured read data.

   // ************************************************************
   // Address decode.
   // ************************************************************
   // Word index is the byte address divided by four.
   wire logic [15:0] idx = avs_address_in[17:2];
   wire logic hit_jsub = (idx[15:2] == mpb_pkg::IDX_JERK_SUB_BASE[15:2]);
   wire logic [1:0] jsub = idx[1:0];
   wire logic hit_jcnt = (idx == mpb_pkg::IDX_JERK_BASE);
   wire logic hit_pu = (idx == mpb_pkg::IDX_POS_UNIT);
   wire logic hit_vu = (idx == mpb_pkg::IDX_VEL_UNIT);
   wire logic hit_po = (idx == mpb_pkg::IDX_POS_OFS);
   wire logic hit_vo = (idx == mpb_pkg::IDX_VEL_OFS);
   wire logic hit_to = (idx == mpb_pkg::IDX_TRQ_OFS);
   wire logic hit_md = (idx == mpb_pkg::IDX_MODE);
   wire logic hit_sp = (idx == mpb_pkg::IDX_SETPOINT);
   wire logic hit_js = (idx == mpb_pkg::IDX_JERK_STAT);
   // A request is taken in the idle state; the answer follows one cycle later.
   wire logic take = (state_q == mpb_pkg::MPB_IDLE) && (avs_read_in || avs_write_in);
   wire logic wr = take && avs_write_in;

   // Jerk limited flags, one per segment: zero turns the limit off.
   wire logic [3:0] jerk_on = {jerk_q[3] != 32'h00000000, jerk_q[2] != 32'h00000000,
                                jerk_q[1] != 32'h00000000, jerk_q[0] != 32'h00000000};

   // Read mux; unmapped addresses read zero and ignore writes.
   wire logic [31:0] rmux =
      hit_jsub ? jerk_q[jsub] :
      hit_jcnt ? {24'h000000, mpb_pkg::JERK_COUNT} :
      hit_pu ? (pos_unit_q & mpb_pkg::POS_UNIT_MASK) :
      hit_vu ? (vel_unit_q & mpb_pkg::VEL_UNIT_MASK) :
      hit_po ? pos_ofs_q :
      hit_vo ? vel_ofs_q :
      hit_to ? {16'h0000, trq_ofs_q} :
      hit_md ? {29'h0, mode_q} :
      hit_sp ? pos_out :
      hit_js ? {28'h0000000, jerk_on} :
      32'h00000000;

   wire logic [31:0] wmerge_pu = be_merge(pos_unit_q, avs_writedata_in, avs_byteenable_in);
   wire logic [31:0] wmerge_vu = be_merge(vel_unit_q, avs_writedata_in, avs_byteenable_in);
   // Torque offset merge is done on a full word and cut to its 16 bits on purpose.
   wire logic [31:0] wmerge_to = be_merge({16'h0000, trq_ofs_q}, avs_writedata_in,
                                          avs_byteenable_in);

   // ************************************************************
   // Bus handshake.
   // ************************************************************
   // Waitrequest is high while idle so every request waits exactly one cycle.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q <= mpb_pkg::MPB_IDLE;
         avs_waitrequest_out <= 1'b1;
         rdata_q <= 32'h00000000;
      end else if (take) begin
         state_q <= mpb_pkg::MPB_ANSWER;
         avs_waitrequest_out <= 1'b0;
         rdata_q <= avs_read_in ? rmux : 32'h00000000;
      end else begin
         state_q <= mpb_pkg::MPB_IDLE;
         avs_waitrequest_out <= 1'b1;
      end
   end

   assign avs_readdata_out = rdata_q;

   // ************************************************************
   // Register writes.
   // ************************************************************
   // Writes land on the take edge, so a read right after sees the new value.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int i = 0; i < 4; i++) begin
            jerk_q[i] <= mpb_pkg::JERK_RESET;
         end
         pos_unit_q <= mpb_pkg::POS_UNIT_RESET;
         vel_unit_q <= mpb_pkg::VEL_UNIT_RESET;
         pos_ofs_q <= mpb_pkg::OFS_RESET;
         vel_ofs_q <= mpb_pkg::OFS_RESET;
         trq_ofs_q <= mpb_pkg::TRQ_RESET;
         mode_q <= mpb_pkg::MODE_OTHER;
      end else if (wr) begin
         if (hit_jsub) begin
            jerk_q[jsub] <= be_merge(jerk_q[jsub], avs_writedata_in, avs_byteenable_in);
         end
         if (hit_pu) begin
            pos_unit_q <= wmerge_pu & mpb_pkg::POS_UNIT_MASK;
         end
         if (hit_vu) begin
            vel_unit_q <= wmerge_vu & mpb_pkg::VEL_UNIT_MASK;
         end
         if (hit_po) begin
            pos_ofs_q <= be_merge(pos_ofs_q, avs_writedata_in, avs_byteenable_in);
         end
         if (hit_vo) begin
            vel_ofs_q <= be_merge(vel_ofs_q, avs_writedata_in, avs_byteenable_in);
         end
         if (hit_to) begin
            trq_ofs_q <= wmerge_to[15:0];
         end
         if (hit_md) begin
            mode_q <= avs_writedata_in[2:0];
         end
      end
   end

   // ************************************************************
   // Ramp and unit outputs.
   // ************************************************************
   // Segment selector picks the jerk for the ramp stage in use.
   wire logic [31:0] jerk_sel =
      (seg_sel_in == mpb_pkg::SEG_BEGIN_ACC) ? jerk_q[0] :
      (seg_sel_in == mpb_pkg::SEG_BEGIN_DEC) ? jerk_q[1] :
      (seg_sel_in == mpb_pkg::SEG_END_ACC) ? jerk_q[2] :
      jerk_q[3];

   // Registers the selected jerk and the decoded unit fields.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         jerk_out <= mpb_pkg::JERK_RESET;
         jerk_limited_out <= 1'b1;
         pos_exp_out <= 8'h00;
         pos_unit_out <= 8'h00;
         vel_exp_out <= 8'h00;
         vel_num_out <= 8'h00;
         vel_den_out <= 8'h00;
      end else begin
         jerk_out <= jerk_sel;
         jerk_limited_out <= jerk_on[seg_sel_in];
         pos_exp_out <= field8(pos_unit_q, mpb_pkg::EXP_LSB);
         pos_unit_out <= field8(pos_unit_q, mpb_pkg::NUM_LSB);
         vel_exp_out <= field8(vel_unit_q, mpb_pkg::EXP_LSB);
         vel_num_out <= field8(vel_unit_q, mpb_pkg::NUM_LSB);
         vel_den_out <= field8(vel_unit_q, mpb_pkg::DEN_LSB);
      end
   end

   // ************************************************************
   // Offset adder.
   // ************************************************************
   mpb_setpoint_adder u_add (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .mode_in(mode_q),
      .pos_set_in(pos_set_in),
      .vel_set_in(vel_set_in),
      .trq_set_in(trq_set_in),
      .pos_ofs_in(pos_ofs_q),
      .vel_ofs_in(vel_ofs_q),
      .trq_ofs_in(trq_ofs_q),
      .pos_out(pos_out),
      .vel_out(vel_out),
      .trq_out(trq_out)
   );

endmodule

// File: tb/mpb_bank_asserts.sv
/* Checker of the parameter bank: concurrent properties on the top ports.
   Assumes it is bound to mpb_bank and sees only that module's ports. */
module mpb_bank_asserts (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [17:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic [1:0] seg_sel_in,
   input wire logic [31:0] pos_set_in,
   input wire logic [31:0] vel_set_in,
   input wire logic [15:0] trq_set_in,
   input wire logic [31:0] jerk_out,
   input wire logic jerk_limited_out,
   input wire logic [7:0] pos_exp_out,
   input wire logic [7:0] pos_unit_out,
   input wire logic [7:0] vel_exp_out,
   input wire logic [7:0] vel_num_out,
   input wire logic [7:0] vel_den_out,
   input wire logic [31:0] pos_out,
   input wire logic [31:0] vel_out,
   input wire logic [15:0] trq_out
);
   // Word index of the request on the bus.
   wire logic [15:0] idx = avs_address_in[17:2];
   // Answer cycle of a read: read data stand only here.
   wire logic rd_ans = !avs_waitrequest_out && avs_read_in;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   // ************************************************************
   // Bus handshake and register contents.
   // ************************************************************
   wait_answer_a: assert property (avs_waitrequest_out && (avs_read_in || avs_write_in)
      |=> !avs_waitrequest_out ##1 avs_waitrequest_out) else $error("no one-cycle answer");
   idle_wait_a: assert property (avs_waitrequest_out && !avs_read_in && !avs_write_in
      |=> avs_waitrequest_out) else $error("answer without request");
   jerk_flag_a: assert property (jerk_limited_out == (jerk_out != 32'h0))
      else $error("jerk flag wrong");
   jerk_sel_a: assert property (rd_ans && idx == mpb_pkg::IDX_JERK_SUB_BASE + seg_sel_in
      && $past(seg_sel_in) == seg_sel_in && $past(seg_sel_in, 2) == seg_sel_in
      |-> avs_readdata_out == jerk_out) else $error("jerk of wrong segment");
   pos_unit_a: assert property (rd_ans && idx == mpb_pkg::IDX_POS_UNIT
      |-> avs_readdata_out == {pos_exp_out, pos_unit_out, 16'h0000}) else $error("pos unit");
   vel_unit_a: assert property (rd_ans && idx == mpb_pkg::IDX_VEL_UNIT
      |-> avs_readdata_out == {vel_exp_out, vel_num_out, vel_den_out, 8'h00})
      else $error("vel unit");
   // Without writes the offset and mode hold, so a sum follows its set value.
   pos_track_a: assert property (!$past(avs_write_in) && !$past(avs_write_in, 2)
      |-> pos_out - $past(pos_out) == $past(pos_set_in) - $past(pos_set_in, 2))
      else $error("pos sum drift");
   vel_track_a: assert property (!$past(avs_write_in) && !$past(avs_write_in, 2)
      |-> vel_out - $past(vel_out) == $past(vel_set_in) - $past(vel_set_in, 2))
      else $error("vel sum drift");
   trq_track_a: assert property (!$past(avs_write_in) && !$past(avs_write_in, 2)
      |-> trq_out - $past(trq_out) == $past(trq_set_in) - $past(trq_set_in, 2))
      else $error("trq sum drift");
   read_c: cover property (rd_ans);
   write_c: cover property (!avs_waitrequest_out && avs_write_in);
   unlimited_c: cover property ($fell(jerk_limited_out));
endmodule

bind mpb_bank mpb_bank_asserts u_mpb_bank_asserts (.*);

// File: tb/mpb_host_model.sv
/* Host model: the fieldbus host reaching the bank as an Avalon-MM master.
   Assumes the bench gives the clock and calls xfer for each access. */
module mpb_host_model (
   input wire logic clk_in,
   input wire logic wait_in,
   input wire logic [31:0] rdata_in,
   output logic [17:0] addr_out,
   output logic rd_out,
   output logic wr_out,
   output logic [3:0] be_out,
   output logic [31:0] wdata_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      addr_out = 18'h00000;
      rd_out = 1'b0;
      wr_out = 1'b0;
      be_out = 4'hF;
      wdata_out = 32'h00000000;
   end
   // One whole access; the request holds until waitrequest is seen low.
   task automatic xfer(input logic w, input logic [15:0] i, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk_in);
      addr_out <= {i, 2'b00};
      rd_out <= !w;
      wr_out <= w;
      wdata_out <= d;
      // Only the bench watchdog may end a wait that never gets an answer.
      do begin
         @(posedge clk_in);
      end while (wait_in !== 1'b0);
      q = rdata_in;
      rd_out <= 1'b0;
      wr_out <= 1'b0;
      // Released data lines show the inverse so stale data never match.
      wdata_out <= ~d;
   endtask
endmodule

// File: tb/testbench.sv
/* Self-checking bench of the parameter bank.
   Assumes mpb_bank, its package and the host model are compiled first. */
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [17:0] avs_address_in;
   logic avs_read_in, avs_write_in;
   logic [3:0] avs_byteenable_in;
   logic [31:0] avs_writedata_in, avs_readdata_out;
   logic avs_waitrequest_out, jerk_limited_out;
   logic [1:0] seg_sel_in = 2'h0;
   logic [31:0] pos_set_in = 32'h0, vel_set_in = 32'h0, jerk_out, pos_out, vel_out, q;
   logic [15:0] trq_set_in = 16'h0, trq_out;
   logic [7:0] pos_exp_out, pos_unit_out, vel_exp_out, vel_num_out, vel_den_out;
   int fails = 0;
   int total_checks = 0;
   always #20 clk_in = ~clk_in;
   mpb_bank u_mpb_bank (.*);
   mpb_host_model u_host (.clk_in(clk_in), .wait_in(avs_waitrequest_out),
      .rdata_in(avs_readdata_out), .addr_out(avs_address_in), .rd_out(avs_read_in),
      .wr_out(avs_write_in), .be_out(avs_byteenable_in), .wdata_out(avs_writedata_in));
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input logic [15:0] i, input logic [31:0] d);
      u_host.xfer(1'b1, i, d, q);
   endtask
   task rd(input logic [15:0] i, input logic [31:0] e);
      u_host.xfer(1'b0, i, 32'h0, q);
      chk("readdata", e, q);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ************************************************************
   // Watchdog: the tests need about a hundred cycles.
   // ************************************************************
   initial begin
      repeat (3000) @(posedge clk_in);
      fails++;
      $display("Error watchdog expected done seen timeout");
      end_sim();
   end
   initial begin
      repeat (2) @(posedge clk_in);
      nrst_in <= 1'b1;
      rd(mpb_pkg::IDX_POS_UNIT, mpb_pkg::POS_UNIT_RESET);
      rd(mpb_pkg::IDX_VEL_UNIT, mpb_pkg::VEL_UNIT_RESET);
      rd(mpb_pkg::IDX_JERK_BASE, 32'h00000004);
      rd(mpb_pkg::IDX_TRQ_OFS, 32'h00000000);
      chk("vel_fields", 32'h00B447, {vel_exp_out, vel_num_out, vel_den_out});
      $display("test preset done");
      // Reserved bits written as ones must read back as zero.
      wr(mpb_pkg::IDX_POS_UNIT, 32'hFFFFFFFF);
      rd(mpb_pkg::IDX_POS_UNIT, 32'hFFFF0000);
      wr(mpb_pkg::IDX_VEL_UNIT, 32'h123456FF);
      rd(mpb_pkg::IDX_VEL_UNIT, 32'h12345600);
      chk("pos_fields", 32'hFFFF, {pos_exp_out, pos_unit_out});
      chk("vel_fields", 32'h123456, {vel_exp_out, vel_num_out, vel_den_out});
      wr(16'h7020, 32'hA5A5A5A5);
      rd(16'h7020, 32'h00000000);
      $display("test units done");
      // Segment SEG_BEGIN_DEC (code 1) carries zero: that ramp segment is unlimited.
      for (int k = 0; k < 4; k++) wr(mpb_pkg::IDX_JERK_SUB_BASE + k, k == 1 ? 0 : 32'h100 + k);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_in);
         seg_sel_in <= k[1:0];
         rd(mpb_pkg::IDX_JERK_SUB_BASE + k, k == 1 ? 0 : 32'h100 + k);
         chk("jerk", k == 1 ? 0 : 32'h100 + k, jerk_out);
         chk("limited", k != 1, {31'h0, jerk_limited_out});
      end
      rd(mpb_pkg::IDX_JERK_STAT, 32'h0000000D);
      $display("test jerk done");
      @(posedge clk_in);
      pos_set_in <= 32'h00001000;
      vel_set_in <= 32'h00002000;
      trq_set_in <= 16'h0300;
      wr(mpb_pkg::IDX_POS_OFS, 32'h00000100);
      wr(mpb_pkg::IDX_VEL_OFS, 32'hFFFFFFFB);
      wr(mpb_pkg::IDX_TRQ_OFS, 32'h0000FFF6);
      rd(mpb_pkg::IDX_TRQ_OFS, 32'h0000FFF6);
      for (int m = 0; m < 5; m++) begin
         wr(mpb_pkg::IDX_MODE, m);
         repeat (2) @(posedge clk_in);
         chk("pos_sum", 32'h1000 + (m == 1 ? 32'h100 : 0), pos_out);
         chk("vel_sum", 32'h2000 + (m inside {1, 2, 4} ? 32'hFFFFFFFB : 0), vel_out);
         chk("trq_sum", 16'(16'h0300 + (m inside {1, 3, 4} ? 16'hFFF6 : 16'h0)), trq_out);
      end
      $display("test offsets done");
      end_sim();
   end
endmodule
